// file: core/rvm_map.svh
// Register offsets, field positions, masks and reset values of the
// regulator voltage and mode register slice.
// Assumes inclusion by bare name from the design files.
`ifndef RVM_MAP_SVH
`define RVM_MAP_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define RVM_OFS_CONV6_SLEEP 8'h99
`define RVM_OFS_LIN2_PAIR 8'h9A
`define RVM_OFS_LIN3_PAIR 8'h9B
`define RVM_OFS_CTRL 8'h9C

// ***************************************************************
// Field positions
// ***************************************************************
`define RVM_CONV6_CODE_MSB 7
`define RVM_CONV6_CODE_LSB 1
`define RVM_PAIR_SLEEP_MSB 7
`define RVM_PAIR_SLEEP_LSB 4
`define RVM_PAIR_NORMAL_MSB 3
`define RVM_PAIR_NORMAL_LSB 0
`define RVM_CTRL_MODE_MSB 5
`define RVM_CTRL_MODE_LSB 3
`define RVM_CTRL_EN_MSB 2
`define RVM_CTRL_EN_LSB 0

// ***************************************************************
// Writable bit masks and reset values
// ***************************************************************
`define RVM_MASK_CONV6 8'hFE
`define RVM_MASK_PAIR 8'hFF
`define RVM_MASK_CTRL 8'h3F
`define RVM_RST_CONV6 8'h00
`define RVM_RST_LIN2 8'h00
`define RVM_RST_LIN3 8'h00
`define RVM_RST_CTRL 8'h07
`define RVM_READ_ZERO 8'h00

`endif

// file: core/rvm_pkg.sv
// Types shared by the regulator voltage and mode register slice.
// Assumes nothing of its surroundings.
`default_nettype none

package rvm_pkg;

	// Which register an address selects
	typedef enum logic [2:0] {
		RVM_SEL_NONE = 3'b000,
		RVM_SEL_CONV6 = 3'b001,
		RVM_SEL_LIN2 = 3'b010,
		RVM_SEL_LIN3 = 3'b011,
		RVM_SEL_CTRL = 3'b100
	} rvm_sel_t;

endpackage : rvm_pkg

`default_nettype wire

// file: core/rvm_sync.sv
// Three-stage synchroniser for pin levels with agreement filter.
// Assumes inputs asynchronous to clk_i and a synchronous-release reset.
`timescale 1ns/1ps
`default_nettype none

module rvm_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_q;

	// A bit moves only where stages two and three agree
	always_comb
	begin
		next_q = (s3 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
	end

	// Stage one feeds stage two only
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q_o <= RST_VAL;
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= next_q;
		end
	end

endmodule : rvm_sync

`default_nettype wire

// file: core/rvm_regs.sv
// Voltage code and controller mode/enable register slice.
// Assumes a serial protocol engine on clk_i drives the register port;
// sleep and enable pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "rvm_map.svh"

module rvm_regs #(
	parameter logic [7:0] RST_CONV6 = `RVM_RST_CONV6,
	parameter logic [7:0] RST_LIN2 = `RVM_RST_LIN2,
	parameter logic [7:0] RST_LIN3 = `RVM_RST_LIN3,
	parameter logic [7:0] RST_CTRL = `RVM_RST_CTRL
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic lin2_sleep_i,
	input wire logic lin3_sleep_i,
	input wire logic [2:0] control_input_pins_i,
	output logic [6:0] conv6_sleep_code_o,
	output logic [3:0] lin2_code_o,
	output logic [3:0] lin3_code_o,
	output logic [2:0] ctrl_pwm_force_o,
	output logic [2:0] ctrl_enable_o
);

	// ***************************************************************
	// Reset release
	// ***************************************************************
	logic rst_meta;
	logic rst_n;

	// Release is delayed two edges so no flop leaves reset mid-cycle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ***************************************************************
	// Address decode
	// ***************************************************************
	function automatic rvm_pkg::rvm_sel_t rvm_decode(input logic [7:0] a);
		rvm_pkg::rvm_sel_t s;
		s = rvm_pkg::RVM_SEL_NONE;
		unique case (a)
			`RVM_OFS_CONV6_SLEEP: s = rvm_pkg::RVM_SEL_CONV6;
			`RVM_OFS_LIN2_PAIR: s = rvm_pkg::RVM_SEL_LIN2;
			`RVM_OFS_LIN3_PAIR: s = rvm_pkg::RVM_SEL_LIN3;
			`RVM_OFS_CTRL: s = rvm_pkg::RVM_SEL_CTRL;
			default: s = rvm_pkg::RVM_SEL_NONE;
		endcase
		return s;
	endfunction : rvm_decode

	// ***************************************************************
	// Register storage
	// ***************************************************************
	logic [7:0] conv6_reg;
	logic [7:0] lin2_reg;
	logic [7:0] lin3_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] next_conv6_reg;
	logic [7:0] next_lin2_reg;
	logic [7:0] next_lin3_reg;
	logic [7:0] next_ctrl_reg;
	logic [7:0] next_rdata;
	rvm_pkg::rvm_sel_t wsel;
	rvm_pkg::rvm_sel_t rsel;

	// Writes land through each register's mask
	always_comb
	begin
		wsel = rvm_decode(reg_addr_i);
		rsel = wsel;
		next_conv6_reg = conv6_reg;
		next_lin2_reg = lin2_reg;
		next_lin3_reg = lin3_reg;
		next_ctrl_reg = ctrl_reg;
		next_rdata = reg_rdata_o;
		if (reg_wr_i)
		begin
			unique case (wsel)
				// seven-bit sleep code, bit 0 reserved
				rvm_pkg::RVM_SEL_CONV6:
					next_conv6_reg = reg_wdata_i & `RVM_MASK_CONV6;
				// sleep and normal nibbles stored together
				rvm_pkg::RVM_SEL_LIN2:
					next_lin2_reg = reg_wdata_i & `RVM_MASK_PAIR;
				// sleep and normal nibbles stored together
				rvm_pkg::RVM_SEL_LIN3:
					next_lin3_reg = reg_wdata_i & `RVM_MASK_PAIR;
				rvm_pkg::RVM_SEL_CTRL:
					next_ctrl_reg = reg_wdata_i & `RVM_MASK_CTRL;
				default: ;
			endcase
		end
		// Read data holds until the next read; unmapped reads zero
		if (reg_rd_i)
		begin
			unique case (rsel)
				rvm_pkg::RVM_SEL_CONV6: next_rdata = conv6_reg;
				rvm_pkg::RVM_SEL_LIN2: next_rdata = lin2_reg;
				rvm_pkg::RVM_SEL_LIN3: next_rdata = lin3_reg;
				rvm_pkg::RVM_SEL_CTRL: next_rdata = ctrl_reg;
				default: next_rdata = `RVM_READ_ZERO;
			endcase
		end
	end

	// Configuration flops
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conv6_reg <= RST_CONV6 & `RVM_MASK_CONV6;
			lin2_reg <= RST_LIN2;
			lin3_reg <= RST_LIN3;
			ctrl_reg <= RST_CTRL & `RVM_MASK_CTRL;
			reg_rdata_o <= `RVM_READ_ZERO;
		end
		else
		begin
			conv6_reg <= next_conv6_reg;
			lin2_reg <= next_lin2_reg;
			lin3_reg <= next_lin3_reg;
			ctrl_reg <= next_ctrl_reg;
			reg_rdata_o <= next_rdata;
		end
	end

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [1:0] sleep_sync;
	logic [2:0] pins_sync;

	rvm_sync #(
		.WIDTH(2),
		.RST_VAL(2'h0)
	) u_sleep_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.d_i({lin3_sleep_i, lin2_sleep_i}),
		.q_o(sleep_sync)
	);

	rvm_sync #(
		.WIDTH(3),
		.RST_VAL(3'h0)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.d_i(control_input_pins_i),
		.q_o(pins_sync)
	);

	// ***************************************************************
	// Regulator-facing outputs
	// ***************************************************************
	logic [6:0] next_conv6_code;
	logic [3:0] next_lin2_code;
	logic [3:0] next_lin3_code;
	logic [2:0] next_pwm;
	logic [2:0] next_en;

	// Codes follow the stored fields one cycle behind
	always_comb
	begin
		next_conv6_code =
			conv6_reg[`RVM_CONV6_CODE_MSB:`RVM_CONV6_CODE_LSB];
		// sleep nibble while sleeping, normal nibble otherwise
		next_lin2_code = sleep_sync[0] ?
			lin2_reg[`RVM_PAIR_SLEEP_MSB:`RVM_PAIR_SLEEP_LSB] :
			lin2_reg[`RVM_PAIR_NORMAL_MSB:`RVM_PAIR_NORMAL_LSB];
		// same selection for the third regulator
		next_lin3_code = sleep_sync[1] ?
			lin3_reg[`RVM_PAIR_SLEEP_MSB:`RVM_PAIR_SLEEP_LSB] :
			lin3_reg[`RVM_PAIR_NORMAL_MSB:`RVM_PAIR_NORMAL_LSB];
		next_pwm = ctrl_reg[`RVM_CTRL_MODE_MSB:`RVM_CTRL_MODE_LSB];
		// software zero overrides the pin for controller three
		// likewise for controllers two and one
		next_en = pins_sync &
			ctrl_reg[`RVM_CTRL_EN_MSB:`RVM_CTRL_EN_LSB];
	end

	// Output flops; enables stay off through reset for safety
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conv6_sleep_code_o <= 7'h00;
			lin2_code_o <= 4'h0;
			lin3_code_o <= 4'h0;
			ctrl_pwm_force_o <= 3'h0;
			ctrl_enable_o <= 3'h0;
		end
		else
		begin
			conv6_sleep_code_o <= next_conv6_code;
			lin2_code_o <= next_lin2_code;
			lin3_code_o <= next_lin3_code;
			ctrl_pwm_force_o <= next_pwm;
			ctrl_enable_o <= next_en;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	a_conv6_code_path: assert property (
		reg_wr_i && reg_addr_i == `RVM_OFS_CONV6_SLEEP
		|=> ##1 conv6_sleep_code_o == $past(reg_wdata_i[7:1], 2))
		else $error("conv6 sleep code not taken from bits 7:1");
	a_lin2_sleep_sel: assert property (
		sleep_sync[0] |=> lin2_code_o == $past(lin2_reg[7:4]))
		else $error("lin2 sleep code wrong");
	a_lin2_normal_sel: assert property (
		!sleep_sync[0] |=> lin2_code_o == $past(lin2_reg[3:0]))
		else $error("lin2 normal code wrong");
	a_lin3_sleep_sel: assert property (
		sleep_sync[1] |=> lin3_code_o == $past(lin3_reg[7:4]))
		else $error("lin3 sleep code wrong");
	a_lin3_normal_sel: assert property (
		!sleep_sync[1] |=> lin3_code_o == $past(lin3_reg[3:0]))
		else $error("lin3 normal code wrong");
	a_pwm_mode_write: assert property (
		reg_wr_i && reg_addr_i == `RVM_OFS_CTRL
		|-> ##2 ctrl_pwm_force_o == $past(reg_wdata_i[5:3], 2))
		else $error("mode bits not applied");
	a_ctrl3_force_off: assert property (
		!ctrl_reg[2] |=> !ctrl_enable_o[2])
		else $error("controller three not forced off");
	a_ctrl12_force_off: assert property (
		(!ctrl_reg[1] || !ctrl_reg[0]) |=>
		ctrl_enable_o[1:0] == ($past(pins_sync[1:0]) &
		$past(ctrl_reg[1:0])))
		else $error("controller one or two override wrong");
	a_sleep_follow: assert property (
		$rose(sleep_sync[0]) |=> lin2_code_o == $past(lin2_reg[7:4]))
		else $error("sleep entry did not switch code");
	a_reserved_zero: assert property (
		reg_rd_i && reg_addr_i == `RVM_OFS_CTRL
		|=> reg_rdata_o[7:6] == 2'h0)
		else $error("reserved control bits read nonzero");
	a_conv6_reserved: assert property (
		reg_rd_i && reg_addr_i == `RVM_OFS_CONV6_SLEEP
		|=> reg_rdata_o[0] == 1'b0)
		else $error("reserved sleep code bit read nonzero");

endmodule : rvm_regs

`default_nettype wire

// file: bench/rvm_host.sv
// Host model: drives the byte register port of the slice.
// Assumes clk_i is shared with the slice; the bench calls acc.
`timescale 1ns/1ps
`default_nettype none

module rvm_host (
	input wire logic clk_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_rd_o
);
	// ***************************************************************
	// Idle levels
	// ***************************************************************
	initial
	begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
	end

	// One-cycle strobe; data inverted after, so stale bytes never match
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = wr;
		reg_rd_o = !wr;
		@(posedge clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = ~d;
	endtask : acc
endmodule : rvm_host
`default_nettype wire

// file: bench/regulator_voltage_mode_regs_bench.sv
// Self-checking bench for the voltage code and mode register slice.
// Assumes rvm_regs with default reset parameters and the host model.
`timescale 1ns/1ps
`default_nettype none

module regulator_voltage_mode_regs_bench;
	logic clk_i;
	logic arst_n_i;
	logic lin2_sleep;
	logic lin3_sleep;
	logic [2:0] pins;
	logic [7:0] addr;
	logic wr;
	logic [7:0] wdata;
	logic rd;
	logic [7:0] rdata;
	logic [6:0] conv6;
	logic [3:0] lin2;
	logic [3:0] lin3;
	logic [2:0] pwm;
	logic [2:0] en;
	logic [7:0] d6, d2, d3, dc;
	logic [2:0] p;
	logic [7:0] expq[$];
	int failures;
	int compares;
	int seed_dummy;

	// ***************************************************************
	// Clock and instances
	// ***************************************************************
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	rvm_host rvm_host_inst (.clk_i(clk_i), .reg_addr_o(addr),
		.reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));

	rvm_regs rvm_regs_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .lin2_sleep_i(lin2_sleep),
		.lin3_sleep_i(lin3_sleep), .control_input_pins_i(pins),
		.conv6_sleep_code_o(conv6), .lin2_code_o(lin2),
		.lin3_code_o(lin3), .ctrl_pwm_force_o(pwm), .ctrl_enable_o(en));

	// ***************************************************************
	// Compare, report and bus helpers
	// ***************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task final_report;
		$display("Counts: compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		rvm_host_inst.acc(1'b0, a, 8'h00);
	endtask : rdx

	task automatic wrx(input logic [7:0] a, input logic [7:0] d);
		rvm_host_inst.acc(1'b1, a, d);
	endtask : wrx

	// Read data lands on the same edge that samples the read strobe; oldest note wins
	always @(posedge clk_i)
		if (rd === 1'b1)
		begin
			#1;
			if (expq.size() > 0)
				chk(rdata, expq.pop_front());
		end

	// Watchdog; the whole run needs well under a thousand cycles
	initial
	begin
		#(20000 * 8);
		failures++;
		final_report();
	end

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial
	begin
		arst_n_i = 1'b0;
		lin2_sleep = 1'b0;
		lin3_sleep = 1'b0;
		pins = 3'h7;
		failures = 0;
		compares = 0;
		seed_dummy = $urandom(32'hC91ACBCF);
		repeat (10) @(posedge clk_i);
		#1;
		arst_n_i = 1'b1;
		repeat (8) @(posedge clk_i);
		// Reset values and the unmapped neighbour below the map
		rdx(8'h99, 8'h00);
		rdx(8'h9A, 8'h00);
		rdx(8'h9B, 8'h00);
		rdx(8'h9C, 8'h07);
		rdx(8'h98, 8'h00);
		#1;
		chk({5'h00, en}, 8'h07);
		// Random fields, pins and sleep levels, then outputs and readback
		for (int i = 0; i < 16; i++)
		begin
			d6 = 8'($urandom);
			d2 = 8'($urandom);
			d3 = 8'($urandom);
			dc = 8'($urandom);
			p = 3'($urandom);
			wrx(8'h99, d6);
			wrx(8'h9A, d2);
			wrx(8'h9B, d3);
			wrx(8'h9C, dc);
			wrx(8'h9D, ~dc);
			lin2_sleep = 1'($urandom);
			lin3_sleep = 1'($urandom);
			pins = p;
			// Pins need the synchroniser's edges before they show
			repeat (8) @(posedge clk_i);
			#1;
			chk({1'b0, conv6}, {1'b0, d6[7:1]});
			chk({4'h0, lin2}, {4'h0, lin2_sleep ? d2[7:4] : d2[3:0]});
			chk({4'h0, lin3}, {4'h0, lin3_sleep ? d3[7:4] : d3[3:0]});
			chk({5'h00, pwm}, {5'h00, dc[5:3]});
			chk({5'h00, en}, {5'h00, dc[2:0] & p});
			rdx(8'h99, d6 & 8'hFE);
			rdx(8'h9A, d2);
			rdx(8'h9B, d3);
			rdx(8'h9C, dc & 8'h3F);
			rdx(8'h9D, 8'h00);
		end
		// Mid-run reset: outputs drop at once, registers go back to defaults
		@(posedge clk_i);
		#1;
		arst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk({5'h00, en}, 8'h00);
		chk({5'h00, pwm}, 8'h00);
		chk({1'b0, conv6}, 8'h00);
		chk(rdata, 8'h00);
		arst_n_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rdx(8'h9A, 8'h00);
		rdx(8'h9C, 8'h07);
		repeat (3) @(posedge clk_i);
		final_report();
	end
endmodule : regulator_voltage_mode_regs_bench
`default_nettype wire
